// *** rtl/mmhi_top.sv ***
// multi-mode host port: strap decode, parallel bus, serial receive crossing
`timescale 1ns/1ns
module mmhi_top
   import mmhi_pkg::*;
(
   // system
   input wire logic clk,
   input wire logic nrst,
   // straps and host control pins
   input wire logic [2:0] iface_select_straps,
   input wire logic cs_n,
   input wire logic dc,
   input wire logic rw_wr_n,
   input wire logic e_rd_n,
   // data pins, split three ways
   input wire logic [7:0] d_in,
   output logic [7:0] d_out,
   output logic [7:0] d_oe,
   // link clock (serial clock on pin 0, supplied separately by the board)
   input wire logic sclk,
   // user side
   output mmhi_xfer_s rx_q,
   output logic rx_valid_q,
   input wire logic [7:0] status_in,
   input wire logic [7:0] rdata_in,
   output logic rd_strobe_q,
   output mmhi_mode_e mode_q
);

   // ****************************************
   // reset release and pin synchronisers
   // ****************************************
   logic [1:0] rst_sync_q;
   wire logic rst_n = rst_sync_q[1];

   // reset release; pulse width is the host's burden, counted in MMHI_RST_CYC
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rst_sync_q <= 2'b00;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   typedef struct packed {
      logic cs_n;
      logic dc;
      logic rw;
      logic e_rd;
      logic [7:0] d;
   } mmhi_pins_s;

   mmhi_pins_s p1_q, p2_q, p3_q;
   wire mmhi_pins_s pins_now = '{cs_n: cs_n, dc: dc, rw: rw_wr_n, e_rd: e_rd_n, d: d_in};

   // two-stage sync, third stage only for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         p1_q <= '{cs_n: 1'b1, dc: 1'b0, rw: 1'b1, e_rd: 1'b1, d: 8'h00};
         p2_q <= '{cs_n: 1'b1, dc: 1'b0, rw: 1'b1, e_rd: 1'b1, d: 8'h00};
         p3_q <= '{cs_n: 1'b1, dc: 1'b0, rw: 1'b1, e_rd: 1'b1, d: 8'h00};
      end else begin
         p1_q <= pins_now;
         p2_q <= p1_q;
         p3_q <= p2_q;
      end
   end

   // ****************************************
   // strap capture
   // ****************************************
   logic [2:0] st1_q, st2_q;
   logic [1:0] caught_q;

   // straps are sampled after release so a strap never feeds the async reset path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st1_q <= 3'h0;
         st2_q <= 3'h0;
         caught_q <= 2'b00;
         mode_q <= MMHI_M_NONE;
      end else begin
         st1_q <= iface_select_straps;
         st2_q <= st1_q;
         // decode only once the second stage holds the straps, so no false mode shows up
         caught_q <= {caught_q[0], 1'b1};
         if (caught_q[1]) mode_q <= mmhi_decode(st2_q);
      end
   end

   wire logic par_8080 = (mode_q == MMHI_M_P8080);
   wire logic par_6800 = (mode_q == MMHI_M_P6800);
   wire logic par_mode = par_8080 | par_6800;
   wire logic i2c_mode = (mode_q == MMHI_M_I2C);

   // ****************************************
   // parallel bus strobes
   // ****************************************
   // 8080: write on wr_n rising, read while rd_n low; 6800: e falling ends cycle, rw picks direction
   logic rd_q;
   wire logic sel = !p2_q.cs_n;
   wire logic wr_8080 = par_8080 && sel && p2_q.rw && !p3_q.rw;
   wire logic wr_6800 = par_6800 && sel && !p2_q.e_rd && p3_q.e_rd && !p3_q.rw;
   wire logic rd_act = sel && (par_8080 ? !p2_q.e_rd : (par_6800 && p2_q.e_rd && p2_q.rw));
   wire logic rd_begin = rd_act && !rd_q;
   wire logic [7:0] rd_val = p2_q.dc ? rdata_in : status_in;

   // ****************************************
   // serial link crossing
   // ****************************************
   logic ser_tgl;
   mmhi_xfer_s ser_word;
   logic ser_ack;
   logic [2:0] tgl_sync_q;
   logic [1:0] ack_sync_q;
   wire logic ser_event = tgl_sync_q[2] ^ tgl_sync_q[1];
   logic i2c_start_q;
   logic [1:0] i2c_sda_q;

   // start condition: data falls while clock is high, seen in clk domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         i2c_sda_q <= 2'b11;
         i2c_start_q <= 1'b0;
      end else begin
         i2c_sda_q <= {i2c_sda_q[0], p2_q.d[MMHI_PIN_SERIAL_DATA_IN]};
         if (i2c_mode && i2c_sda_q[1] && !i2c_sda_q[0] && p2_q.d[MMHI_PIN_SCLK]) i2c_start_q <= 1'b1;
         else if (i2c_mode && !p2_q.d[MMHI_PIN_SCLK]) i2c_start_q <= 1'b0;
      end
   end

   mmhi_serial_rx u_ser (
      .sclk(sclk),
      .rst_n(rst_n),
      .cs_n(i2c_mode ? 1'b0 : cs_n),
      .mode(mode_q),
      .serial_data_in(d_in[MMHI_PIN_SERIAL_DATA_IN]),
      .dc(dc),
      .i2c_start(i2c_mode & i2c_start_q),
      .tgl_q(ser_tgl),
      .word_q(ser_word),
      .ack_q(ser_ack)
   );

   // toggle crossing; word is stable for a full byte time after the toggle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_sync_q <= 3'h0;
         ack_sync_q <= 2'h0;
      end else begin
         tgl_sync_q <= {tgl_sync_q[1:0], ser_tgl};
         ack_sync_q <= {ack_sync_q[0], ser_ack};
      end
   end

   // ****************************************
   // user side byte and pin drive
   // ****************************************
   wire logic par_wr = wr_8080 | wr_6800;
   wire logic [7:0] oe_d = par_mode ? (rd_act ? 8'hff : 8'h00)
                         : ((i2c_mode && ack_sync_q[1]) ? 8'h04 : 8'h00);

   // one output word register; parallel and serial never both active in one mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_q <= '0;
         rx_valid_q <= 1'b0;
         rd_q <= 1'b0;
         rd_strobe_q <= 1'b0;
         d_out <= 8'h00;
         d_oe <= 8'h00;
      end else begin
         rx_valid_q <= par_wr | (ser_event & ~par_mode);
         if (par_wr) rx_q <= '{is_data: p2_q.dc, byte_val: p2_q.d};
         else if (ser_event && !par_mode) rx_q <= ser_word;
         rd_q <= rd_act;
         rd_strobe_q <= rd_begin;
         if (rd_begin) d_out <= rd_val;
         else if (!par_mode) d_out <= 8'h00; // i2c ack pulls pin 2 low
         d_oe <= oe_d;
      end
   end

endmodule : mmhi_top

// *** rtl/mmhi_pkg.sv ***
// package: mode codes, pin roles, transfer carrier and timing counts for the host interface
package mmhi_pkg;

   // ****************************************
   // interface select strap codes
   // ****************************************
   localparam logic [2:0] MMHI_SEL_SPI4 = 3'h0;
   localparam logic [2:0] MMHI_SEL_SPI3 = 3'h1;
   localparam logic [2:0] MMHI_SEL_I2C = 3'h2;
   localparam logic [2:0] MMHI_SEL_P8080 = 3'h6;
   localparam logic [2:0] MMHI_SEL_P6800 = 3'h4;

   // ****************************************
   // data pin roles in serial modes
   // ****************************************
   localparam int MMHI_PIN_SCLK = 0;
   localparam int MMHI_PIN_SERIAL_DATA_IN = 1;
   localparam int MMHI_PIN_SDAO = 2;

   // ****************************************
   // bus and timing constants
   // ****************************************
   localparam int MMHI_BYTE_W = 8;
   localparam logic [6:0] MMHI_I2C_ADDR = 7'h3c;
   localparam int MMHI_RST_MIN_NS = 100000;
   localparam int MMHI_CLK_NS = 10;
   localparam int MMHI_RST_CYC = (MMHI_RST_MIN_NS + MMHI_CLK_NS - 1) / MMHI_CLK_NS;
   localparam logic [7:0] MMHI_STATUS_RST = 8'h00;

   // decoded interface mode, one-hot
   typedef enum logic [5:0] {
      MMHI_M_SPI4 = 6'b00_0001,
      MMHI_M_SPI3 = 6'b00_0010,
      MMHI_M_I2C = 6'b00_0100,
      MMHI_M_P8080 = 6'b00_1000,
      MMHI_M_P6800 = 6'b01_0000,
      MMHI_M_NONE = 6'b10_0000
   } mmhi_mode_e;

   // one received byte with its routing
   typedef struct packed {
      logic is_data;
      logic [7:0] byte_val;
   } mmhi_xfer_s;

   // strap decode, used only at strap capture; the serial engine takes the decoded mode
   function automatic mmhi_mode_e mmhi_decode(input logic [2:0] sel);
      case (sel)
         MMHI_SEL_SPI4: mmhi_decode = MMHI_M_SPI4;
         MMHI_SEL_SPI3: mmhi_decode = MMHI_M_SPI3;
         MMHI_SEL_I2C: mmhi_decode = MMHI_M_I2C;
         MMHI_SEL_P8080: mmhi_decode = MMHI_M_P8080;
         MMHI_SEL_P6800: mmhi_decode = MMHI_M_P6800;
         default: mmhi_decode = MMHI_M_NONE;
      endcase
   endfunction : mmhi_decode

endpackage : mmhi_pkg

// *** rtl/mmhi_serial_rx.sv ***
// serial byte receiver running on the host serial clock (spi and i2c)
`timescale 1ns/1ns
module mmhi_serial_rx
   import mmhi_pkg::*;
(
   // link clock and frame
   input wire logic sclk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic [5:0] mode,
   // serial lines
   input wire logic serial_data_in,
   input wire logic dc,
   input wire logic i2c_start,
   // byte out: toggle event plus held word
   output logic tgl_q,
   output mmhi_xfer_s word_q,
   output logic ack_q
);

   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic dcbit_q;
   logic addr_ok_q;
   logic addr_ph_q;
   logic ctl_ph_q;

   wire logic is_spi3 = (mode == MMHI_M_SPI3);
   wire logic is_i2c = (mode == MMHI_M_I2C);
   wire logic [3:0] frame_len = is_spi3 ? 4'd9 : (is_i2c ? 4'd9 : 4'd8);
   wire logic last_bit = (cnt_q == frame_len - 4'd1);
   wire logic [7:0] sh_next = {sh_q[6:0], serial_data_in};
   // spi3 carries data/command as the first bit of each 9-bit frame
   wire logic dc_now = is_spi3 ? dcbit_q : dc;

   // shift on rising serial clock; chip select frames spi transfers, start frames i2c
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         dcbit_q <= 1'b0;
         tgl_q <= 1'b0;
         word_q <= '0;
         ack_q <= 1'b0;
         addr_ok_q <= 1'b0;
         addr_ph_q <= 1'b1;
         ctl_ph_q <= 1'b0;
      end else if (cs_n || i2c_start) begin
         cnt_q <= 4'h0;
         addr_ph_q <= 1'b1;
         ctl_ph_q <= i2c_start;
         ack_q <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         if (is_spi3 && cnt_q == 4'h0) begin
            dcbit_q <= serial_data_in;
            cnt_q <= 4'h1;
         end else if (is_i2c && cnt_q == 4'd8) begin
            cnt_q <= 4'h0; // ack slot
         end else begin
            sh_q <= sh_next;
            cnt_q <= last_bit ? 4'h0 : cnt_q + 4'h1;
            if (is_i2c && cnt_q == 4'd7) begin
               ack_q <= addr_ph_q ? (sh_next[7:1] == MMHI_I2C_ADDR) : addr_ok_q;
               if (addr_ph_q) begin
                  addr_ok_q <= (sh_next[7:1] == MMHI_I2C_ADDR) && !sh_next[0];
                  addr_ph_q <= 1'b0;
                  ctl_ph_q <= 1'b1;
               end else if (ctl_ph_q) begin
                  dcbit_q <= sh_next[6]; // control byte carries data/command
                  ctl_ph_q <= 1'b0;
               end else if (addr_ok_q) begin
                  word_q <= '{is_data: dcbit_q, byte_val: sh_next};
                  tgl_q <= ~tgl_q;
               end
            end else if (!is_i2c && last_bit) begin
               word_q <= '{is_data: dc_now, byte_val: sh_next};
               tgl_q <= ~tgl_q;
            end
         end
      end
   end

endmodule : mmhi_serial_rx

// *** bench/mmhi_props.sv ***
// checker: port relations of the host port
`timescale 1ns/1ns
module mmhi_props
   import mmhi_pkg::*;
(
   // watched ports
   input wire logic clk,
   input wire logic nrst,
   input wire logic [2:0] iface_select_straps,
   input wire logic cs_n,
   input wire logic dc,
   input wire logic rw_wr_n,
   input wire logic [7:0] d_out,
   input wire logic [7:0] d_oe,
   input wire logic rx_valid_q,
   input wire logic [7:0] status_in,
   input wire logic [7:0] rdata_in,
   input wire logic rd_strobe_q,
   input wire mmhi_mode_e mode_q
);
   // ****
   // helpers
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [3:0] cs_cnt_q;
   wire logic [2:0] s = iface_select_straps;
   wire mmhi_mode_e exp_m = s == 3'h0 ? MMHI_M_SPI4 : s == 3'h1 ? MMHI_M_SPI3 : s == 3'h2 ? MMHI_M_I2C :
      s == 3'h6 ? MMHI_M_P8080 : s == 3'h4 ? MMHI_M_P6800 : MMHI_M_NONE;
   // deselect time, saturating so long idles stay covered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cs_cnt_q <= 4'h0;
      else if (!cs_n) cs_cnt_q <= 4'h0;
      else if (cs_cnt_q != 4'hf) cs_cnt_q <= cs_cnt_q + 4'h1;
   end
   sequence s_wr_take; mode_q == MMHI_M_P8080 && !cs_n && $rose(rw_wr_n); endsequence
   sequence s_byte_out; ##[3:5] rx_valid_q; endsequence
   property p_mode; mode_q != MMHI_M_NONE |-> mode_q == exp_m; endproperty
   property p_serial_quiet; mode_q == MMHI_M_SPI4 || mode_q == MMHI_M_SPI3 |-> d_oe == 8'h00; endproperty
   property p_i2c_pins; mode_q == MMHI_M_I2C |-> (d_oe & 8'hfb) == 8'h00; endproperty
   property p_wr_answer; s_wr_take |-> s_byte_out; endproperty
   property p_cs_block; cs_cnt_q == 4'hf |-> !rx_valid_q && !rd_strobe_q; endproperty
   property p_rd_src; rd_strobe_q |-> d_oe == 8'hff && d_out == (dc ? rdata_in : status_in); endproperty
   property p_rd_hold; rd_strobe_q |=> (d_oe == 8'hff) [*2]; endproperty
   property p_rx_pulse; rx_valid_q |=> !rx_valid_q; endproperty
   a_mode: assert property (p_mode) else $error("mode differs from straps");
   a_serial_quiet: assert property (p_serial_quiet) else $error("pins driven in spi");
   a_i2c_pins: assert property (p_i2c_pins) else $error("i2c drives other pin");
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   a_cs_block: assert property (p_cs_block) else $error("activity while deselected");
   a_rd_src: assert property (p_rd_src) else $error("wrong read source");
   a_rd_hold: assert property (p_rd_hold) else $error("read drive dropped");
   a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse too long");
endmodule : mmhi_props
bind mmhi_top mmhi_props u_props (.clk(clk), .nrst(nrst), .iface_select_straps(iface_select_straps),
   .cs_n(cs_n), .dc(dc), .rw_wr_n(rw_wr_n), .d_out(d_out), .d_oe(d_oe), .rx_valid_q(rx_valid_q),
   .status_in(status_in), .rdata_in(rdata_in), .rd_strobe_q(rd_strobe_q), .mode_q(mode_q));

// *** bench/mmhi_host_model.sv ***
// host model: parallel strobes and serial frames toward the port
`timescale 1ns/1ns
module mmhi_host_model (
   // device drive
   input wire logic clk,
   input wire logic [7:0] d_out,
   input wire logic [7:0] d_oe,
   // host pins
   output logic cs_n,
   output logic dc,
   output logic rw_wr_n,
   output logic e_rd_n,
   output logic sclk,
   output logic [7:0] d_in
);
   logic [7:0] h_val;
   logic h_en;
   // released pins show the inverse, so a stale value never passes
   assign d_in = (d_oe & d_out) | (~d_oe & ((h_en ? h_val : ~h_val) | {7'h00, sclk}));
   initial begin
      {cs_n, dc, rw_wr_n, e_rd_n, sclk, h_en} = 6'b101101;
      h_val = 8'h00;
   end
   // one strobe; 6800 takes at enable fall, 8080 at strobe rise
   task automatic par(input logic m68, input logic rd, input logic sel_n, input logic d_c,
                      input logic [7:0] b, output logic [7:0] q);
      @(negedge clk);
      rw_wr_n = m68 ? rd : 1'b1;
      e_rd_n = !m68;
      @(negedge clk);
      cs_n = sel_n;
      dc = d_c;
      h_val = b;
      h_en = !rd;
      if (m68) e_rd_n = 1'b1;
      else if (rd) e_rd_n = 1'b0;
      else rw_wr_n = 1'b0;
      repeat (6) @(negedge clk);
      q = d_in;
      e_rd_n = !m68;
      rw_wr_n = m68 ? rw_wr_n : 1'b1;
      @(negedge clk);
      {cs_n, rw_wr_n, h_en} = 3'b111;
      h_val = 8'h00;
      repeat (6) @(negedge clk);
   endtask : par
   // serial frame, clock still outside it; spi3 puts dc first
   task automatic spi(input logic three, input logic d_c, input logic [7:0] b);
      logic [8:0] bits;
      bits = three ? {d_c, b} : {b, 1'b0};
      @(negedge clk);
      cs_n = 1'b0;
      dc = three ? !d_c : d_c;
      #7;
      for (int i = 8; i >= (three ? 0 : 1); i--) begin
         h_val = {6'h00, bits[i], 1'b0};
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      repeat (10) @(negedge clk);
      cs_n = 1'b1;
      h_val = 8'h00;
   endtask : spi
endmodule : mmhi_host_model

// *** bench/multi_mode_host_interface_tb.sv ***
// testbench: strap decode, parallel and serial transfers
`timescale 1ns/1ns
module multi_mode_host_interface_tb;
   import mmhi_pkg::*;
   logic clk, nrst, cs_n, dc, rw_wr_n, e_rd_n, sclk, rx_valid_q, rd_strobe_q;
   logic [2:0] straps;
   logic [7:0] d_in, d_out, d_oe, status_in, rdata_in;
   mmhi_xfer_s rx_q, last_rx;
   mmhi_mode_e mode_q;
   int err_total, n_checks, n_rx;
   mmhi_top dut (.clk(clk), .nrst(nrst), .iface_select_straps(straps), .cs_n(cs_n), .dc(dc),
      .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .sclk(sclk),
      .rx_q(rx_q), .rx_valid_q(rx_valid_q), .status_in(status_in), .rdata_in(rdata_in),
      .rd_strobe_q(rd_strobe_q), .mode_q(mode_q));
   mmhi_host_model host (.clk(clk), .d_out(d_out), .d_oe(d_oe), .cs_n(cs_n), .dc(dc),
      .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n), .sclk(sclk), .d_in(d_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // received bytes, kept for the scenarios
   always @(posedge clk) begin
      if (rx_valid_q === 1'b1) begin
         last_rx <= rx_q;
         n_rx <= n_rx + 1;
      end
   end
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // pulse shortened; straps only change while held
   task automatic rst(input logic [2:0] code);
      @(negedge clk);
      nrst = 1'b0;
      straps = code;
      repeat (8) @(negedge clk);
      chk("oe in reset", d_oe, 8'h00);
      nrst = 1'b1;
      repeat (8) @(negedge clk);
   endtask : rst
   task automatic t_modes();
      mmhi_mode_e exp [8];
      exp = '{MMHI_M_SPI4, MMHI_M_SPI3, MMHI_M_I2C, MMHI_M_NONE, MMHI_M_P6800, MMHI_M_NONE, MMHI_M_P8080,
         MMHI_M_NONE};
      for (int c = 0; c < 8; c++) begin
         rst(3'(c));
         chk("mode", mode_q, exp[c]);
      end
   endtask : t_modes
   task automatic t_par(input logic m68);
      logic [7:0] q;
      int n0;
      rst(m68 ? MMHI_SEL_P6800 : MMHI_SEL_P8080);
      host.par(m68, 1'b0, 1'b0, 1'b0, 8'h5a, q);
      chk("cmd byte", last_rx, {1'b0, 8'h5a});
      host.par(m68, 1'b0, 1'b0, 1'b1, 8'ha5, q);
      chk("data byte", last_rx, {1'b1, 8'ha5});
      n0 = n_rx;
      host.par(m68, 1'b0, 1'b1, 1'b1, 8'h0f, q);
      chk("deselected write", 16'(n_rx), 16'(n0));
      host.par(m68, 1'b1, 1'b0, 1'b0, 8'h00, q);
      chk("status read", q, status_in);
      host.par(m68, 1'b1, 1'b0, 1'b1, 8'h00, q);
      chk("data read", q, rdata_in);
   endtask : t_par
   task automatic t_spi();
      rst(MMHI_SEL_SPI4);
      host.spi(1'b0, 1'b1, 8'h96);
      chk("spi4 byte", last_rx, {1'b1, 8'h96});
      rst(MMHI_SEL_SPI3);
      host.spi(1'b1, 1'b0, 8'h81);
      chk("spi3 byte", last_rx, {1'b0, 8'h81});
   endtask : t_spi
   initial begin
      {nrst, straps, n_rx, err_total, n_checks} = '0;
      last_rx = '0;
      status_in = 8'h3c;
      rdata_in = 8'hc3;
      t_modes();
      t_par(1'b0);
      t_par(1'b1);
      t_spi();
      wrap_up();
   end
   // whole run is near 5 us; about sixty times that means a hang
   initial begin
      #300_000;
      err_total++;
      wrap_up();
   end
endmodule : multi_mode_host_interface_tb
